// ---- lcd_port_pkg.sv ----
// shared constants and types for the display host bus port
package lcd_port_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [3:0]  ADDR_RX         = 4'h0;
    localparam logic [3:0]  ADDR_STATUS     = 4'h4;
    localparam logic [3:0]  ADDR_RDDATA     = 4'h8;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int          RX_DC_BIT       = 8;
    localparam int          RX_VALID_BIT    = 9;
    localparam int          ST_OVERRUN_BIT  = 0;
    localparam int          ST_READ_BIT     = 1;
    localparam int          ST_PARALLEL_BIT = 2;
    localparam int          ST_STYLE_BIT    = 3;
    localparam int          ST_INIT_BIT     = 4;
    localparam int          RDD_STATUS_LSB  = 8;
    localparam logic [15:0] RDDATA_RST      = 16'h0000;
    localparam logic [8:0]  RX_RST          = 9'h000;

    // ****************************************
    // serial framing
    // ****************************************
    localparam logic [2:0]  SERIAL_LAST     = 3'h7;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic       parallel;
        logic       style;
        logic       dc;
        logic       unit_select_n;
        logic       rd_e;
        logic       wr_rw;
        logic [7:0] data;
    } host_pins_t;

    typedef struct packed {
        logic       dc;
        logic [7:0] data;
    } link_byte_t;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] display;
    } read_pair_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_t;

endpackage

// ---- lcd_host_bus_port.sv ----
// host bus port: 8080 / 6800 parallel and serial byte intake with avalon register access
//
// Notes on behaviour
// RULE_01: parallel pin high parallel, low serial.
// RULE_02: serial mode is write only.
// RULE_03: host ties data bits 0..5 high serially.
// RULE_04: serial data on bit 7, clock bit 6.
// RULE_05: serial mode never drives data bits 0..5.
// RULE_06: host holds strobes steady in serial mode.
// RULE_07: style pin high 6800, low 8080.
// RULE_08: 8080 drives bus only while read low.
// RULE_09: 8080 captures data at write rising edge.
// RULE_10: 6800 enable pin qualifies every transfer.
// RULE_11: 6800 direction high reads, low writes.
// RULE_12: payload select high data, low command.
// RULE_13: transfers only while unit select low.
// RULE_14: unit select inactive floats all data lines.
// RULE_15: init pin low clears registers, level acting.
// RULE_16: host holds init low one microsecond minimum.
// RULE_17: serial byte eight bits msb first, rising.
`timescale 1ns/1ps
module lcd_host_bus_port (
    input  wire logic                     clk_sys,
    input  wire logic                     rstn,
    input  wire logic                     link_clk,
    input  wire logic [3:0]               avs_address,
    input  wire logic                     avs_read,
    input  wire logic                     avs_write,
    input  wire logic [31:0]              avs_writedata,
    output logic [31:0]                   avs_readdata,
    output logic                          avs_waitrequest,
    input  wire lcd_port_pkg::host_pins_t pins,
    input  wire logic                     init_pin_n,
    output logic [7:0]                    data_out,
    output logic [7:0]                    data_oe
);
    import lcd_port_pkg::*;

    // ****************************************
    // edge and address helpers
    // ****************************************
    function automatic logic rising(input logic prev, input logic now_v);
        return !prev && now_v;
    endfunction

    function automatic logic falling(input logic prev, input logic now_v);
        return prev && !now_v;
    endfunction

    // one decode per side effect keeps the accept edge the only trigger
    function automatic logic addr_hit(input logic       go,
                                      input logic [3:0] a,
                                      input logic [3:0] want);
        return go && (a == want);
    endfunction

    // ****************************************
    // link domain: pin synchronisers
    // ****************************************
    host_pins_t pin_m_r;
    host_pins_t pin_s_r;
    host_pins_t pin_p_r;
    logic       init_lm_r;
    logic       init_ls_r;
    logic       pair_tgl_m_r;
    logic       pair_tgl_s_r;
    logic       pair_tgl_p_r;
    // written on the system side, read here only after its toggle settles
    read_pair_t pair_hold_r;
    logic       pair_tgl_r;

    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            pin_m_r      <= '0;
            pin_s_r      <= '0;
            pin_p_r      <= '0;
            init_lm_r    <= 1'b0;
            init_ls_r    <= 1'b0;
            pair_tgl_m_r <= 1'b0;
            pair_tgl_s_r <= 1'b0;
            pair_tgl_p_r <= 1'b0;
        end else begin
            pin_m_r      <= pins;
            pin_s_r      <= pin_m_r;
            pin_p_r      <= pin_s_r;
            init_lm_r    <= init_pin_n;
            init_ls_r    <= init_lm_r;
            pair_tgl_m_r <= pair_tgl_r;
            pair_tgl_s_r <= pair_tgl_m_r;
            pair_tgl_p_r <= pair_tgl_s_r;
        end
    end

    // ****************************************
    // link domain: transfer engine
    // ****************************************
    link_byte_t byte_l_r;
    link_byte_t byte_l_nxt;
    logic       wr_tgl_r;
    logic       wr_tgl_nxt;
    logic       rd_tgl_r;
    logic       rd_tgl_nxt;
    logic       drive_r;
    logic       drive_nxt;
    logic [6:0] shift_r;
    logic [6:0] shift_nxt;
    logic [2:0] bit_cnt_r;
    logic [2:0] bit_cnt_nxt;
    read_pair_t pair_l_r;
    read_pair_t pair_l_nxt;
    logic [7:0] data_out_nxt;
    logic [7:0] data_oe_nxt;

    always_comb begin
        logic sel;
        logic wr_edge;
        logic sclk_rise;
        sel          = !pin_s_r.unit_select_n;                              // RULE_13
        wr_edge      = 1'b0;
        sclk_rise    = 1'b0;
        byte_l_nxt   = byte_l_r;
        wr_tgl_nxt   = wr_tgl_r;
        rd_tgl_nxt   = rd_tgl_r;
        drive_nxt    = 1'b0;
        shift_nxt    = shift_r;
        bit_cnt_nxt  = bit_cnt_r;
        pair_l_nxt   = pair_l_r;
        data_out_nxt = data_out;
        data_oe_nxt  = 8'h00;                                               // RULE_14
        if (pair_tgl_s_r != pair_tgl_p_r) begin
            pair_l_nxt = pair_hold_r;
        end
        if (pin_s_r.parallel) begin                                         // RULE_01
            bit_cnt_nxt = 3'h0;
            if (pin_s_r.style) begin                                        // RULE_07
                // 6800: latch on enable falling with direction low
                wr_edge   = sel && falling(pin_p_r.rd_e, pin_s_r.rd_e)
                            && !pin_s_r.wr_rw;                              // RULE_10 RULE_11
                drive_nxt = sel && pin_s_r.rd_e && pin_s_r.wr_rw;           // RULE_11
            end else begin
                wr_edge   = sel && rising(pin_p_r.wr_rw, pin_s_r.wr_rw);    // RULE_09
                drive_nxt = sel && !pin_s_r.rd_e;                           // RULE_08
            end
            if (wr_edge) begin
                byte_l_nxt.dc   = pin_s_r.dc;                               // RULE_12
                byte_l_nxt.data = pin_s_r.data;
                wr_tgl_nxt      = !wr_tgl_r;
            end
        end else begin
            // serial: no drive at all, strobe pins ignored
            drive_nxt = 1'b0;                                               // RULE_02 RULE_05 RULE_06
            sclk_rise = rising(pin_p_r.data[6], pin_s_r.data[6]);           // RULE_04
            if (!sel) begin
                bit_cnt_nxt = 3'h0;
            end else if (sclk_rise) begin
                shift_nxt   = {shift_r[5:0], pin_s_r.data[7]};              // RULE_17
                bit_cnt_nxt = bit_cnt_r + 3'h1;
                if (bit_cnt_r == SERIAL_LAST) begin
                    byte_l_nxt.dc   = pin_s_r.dc;                           // RULE_17 RULE_12
                    byte_l_nxt.data = {shift_r, pin_s_r.data[7]};
                    wr_tgl_nxt      = !wr_tgl_r;
                    bit_cnt_nxt     = 3'h0;
                end
            end
        end
        // data held between reads; only the enable moves on release
        if (drive_nxt) begin
            data_oe_nxt  = 8'hff;
            data_out_nxt = pin_s_r.dc ? pair_l_r.display : pair_l_r.status; // RULE_12
        end
        if (drive_r && !drive_nxt) begin
            rd_tgl_nxt = !rd_tgl_r;
        end
        if (!init_ls_r) begin
            // level-held init: abandon any half-shifted byte
            bit_cnt_nxt = 3'h0;                                             // RULE_15
            shift_nxt   = 7'h00;
            pair_l_nxt  = RDDATA_RST;
        end
    end

    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            byte_l_r  <= '0;
            wr_tgl_r  <= 1'b0;
            rd_tgl_r  <= 1'b0;
            drive_r   <= 1'b0;
            shift_r   <= 7'h00;
            bit_cnt_r <= 3'h0;
            pair_l_r  <= RDDATA_RST;
            data_out  <= 8'h00;
            data_oe   <= 8'h00;
        end else begin
            byte_l_r  <= byte_l_nxt;
            wr_tgl_r  <= wr_tgl_nxt;
            rd_tgl_r  <= rd_tgl_nxt;
            drive_r   <= drive_nxt;
            shift_r   <= shift_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            pair_l_r  <= pair_l_nxt;
            data_out  <= data_out_nxt;
            data_oe   <= data_oe_nxt;
        end
    end

    // ****************************************
    // system domain: synchronisers
    // ****************************************
    logic       wr_tgl_m_r;
    logic       wr_tgl_s_r;
    logic       wr_tgl_p_r;
    logic       rd_tgl_m_r;
    logic       rd_tgl_s_r;
    logic       rd_tgl_p_r;
    logic       init_m_r;
    logic       init_s_r;
    // mode pins sit still in use, so a plain two-flop pass is enough
    logic [1:0] mode_m_r;
    logic [1:0] mode_s_r;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wr_tgl_m_r <= 1'b0;
            wr_tgl_s_r <= 1'b0;
            wr_tgl_p_r <= 1'b0;
            rd_tgl_m_r <= 1'b0;
            rd_tgl_s_r <= 1'b0;
            rd_tgl_p_r <= 1'b0;
            init_m_r   <= 1'b0;
            init_s_r   <= 1'b0;
            mode_m_r   <= 2'b00;
            mode_s_r   <= 2'b00;
        end else begin
            wr_tgl_m_r <= wr_tgl_r;
            wr_tgl_s_r <= wr_tgl_m_r;
            wr_tgl_p_r <= wr_tgl_s_r;
            rd_tgl_m_r <= rd_tgl_r;
            rd_tgl_s_r <= rd_tgl_m_r;
            rd_tgl_p_r <= rd_tgl_s_r;
            init_m_r   <= init_pin_n;
            init_s_r   <= init_m_r;
            mode_m_r   <= {pins.style, pins.parallel};
            mode_s_r   <= mode_m_r;
        end
    end

    // ****************************************
    // system domain: registers and avalon slave
    // ****************************************
    bus_state_t bus_r;
    bus_state_t bus_nxt;
    logic [8:0] rx_r;
    logic [8:0] rx_nxt;
    logic       rx_valid_r;
    logic       rx_valid_nxt;
    logic       overrun_r;
    logic       overrun_nxt;
    logic       read_done_r;
    logic       read_done_nxt;
    read_pair_t pair_hold_nxt;
    logic       pair_tgl_nxt;
    logic [31:0] rdata_nxt;
    logic        wait_nxt;

    always_comb begin
        logic take;
        logic take_rd;
        logic take_wr;
        logic got_byte;
        logic got_read;
        got_byte      = wr_tgl_s_r != wr_tgl_p_r;
        got_read      = rd_tgl_s_r != rd_tgl_p_r;
        take          = (bus_r == BUS_ACK) && (avs_read || avs_write);
        take_rd       = take && avs_read;
        take_wr       = take && avs_write;
        bus_nxt       = bus_r;
        rx_nxt        = rx_r;
        rx_valid_nxt  = rx_valid_r;
        overrun_nxt   = overrun_r;
        read_done_nxt = read_done_r;
        pair_hold_nxt = pair_hold_r;
        pair_tgl_nxt  = pair_tgl_r;
        rdata_nxt     = avs_readdata;
        wait_nxt      = 1'b1;
        case (bus_r)
            BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    bus_nxt   = BUS_ACK;
                    wait_nxt  = 1'b0;
                    rdata_nxt = 32'h0000_0000;
                    if (avs_read) begin
                        case (avs_address)
                            ADDR_RX: begin
                                rdata_nxt[8:0]        = rx_r;
                                rdata_nxt[RX_VALID_BIT] = rx_valid_r;
                            end
                            ADDR_STATUS: begin
                                rdata_nxt[ST_OVERRUN_BIT]  = overrun_r;
                                rdata_nxt[ST_READ_BIT]     = read_done_r;
                                rdata_nxt[ST_PARALLEL_BIT] = mode_s_r[0];
                                rdata_nxt[ST_STYLE_BIT]    = mode_s_r[1];
                                rdata_nxt[ST_INIT_BIT]     = !init_s_r;
                            end
                            ADDR_RDDATA: rdata_nxt[15:0] = pair_hold_r;
                            default:     rdata_nxt = 32'h0000_0000;
                        endcase
                    end
                end
            end
            BUS_ACK: begin
                bus_nxt = BUS_IDLE;
            end
            default: begin
                bus_nxt = BUS_IDLE;
            end
        endcase
        // software side effects, taken at the accepting edge only
        if (addr_hit(take_rd, avs_address, ADDR_RX)) begin
            rx_valid_nxt = 1'b0;
        end
        if (addr_hit(take_wr, avs_address, ADDR_STATUS)) begin
            overrun_nxt   = overrun_r & !avs_writedata[ST_OVERRUN_BIT];
            read_done_nxt = read_done_r & !avs_writedata[ST_READ_BIT];
        end
        // back-to-back copies closer than three link clocks may merge
        if (addr_hit(take_wr, avs_address, ADDR_RDDATA)) begin
            pair_hold_nxt.display = avs_writedata[7:0];
            pair_hold_nxt.status  = avs_writedata[RDD_STATUS_LSB +: 8];
            pair_tgl_nxt          = !pair_tgl_r;
        end
        // hardware sets win over software clears
        if (got_byte) begin
            rx_nxt       = {byte_l_r.dc, byte_l_r.data};                    // RULE_12
            overrun_nxt  = overrun_nxt | rx_valid_r;
            rx_valid_nxt = 1'b1;
        end
        if (got_read) begin
            read_done_nxt = 1'b1;
        end
        if (!init_s_r) begin
            rx_nxt        = RX_RST;                                         // RULE_15
            rx_valid_nxt  = 1'b0;
            overrun_nxt   = 1'b0;
            read_done_nxt = 1'b0;
            pair_hold_nxt = RDDATA_RST;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bus_r           <= BUS_IDLE;
            rx_r            <= RX_RST;
            rx_valid_r      <= 1'b0;
            overrun_r       <= 1'b0;
            read_done_r     <= 1'b0;
            pair_hold_r     <= RDDATA_RST;
            pair_tgl_r      <= 1'b0;
            avs_readdata    <= 32'h0000_0000;
            avs_waitrequest <= 1'b1;
        end else begin
            bus_r           <= bus_nxt;
            rx_r            <= rx_nxt;
            rx_valid_r      <= rx_valid_nxt;
            overrun_r       <= overrun_nxt;
            read_done_r     <= read_done_nxt;
            pair_hold_r     <= pair_hold_nxt;
            pair_tgl_r      <= pair_tgl_nxt;
            avs_readdata    <= rdata_nxt;
            avs_waitrequest <= wait_nxt;
        end
    end

endmodule

// ---- lcd_host_bus_port_properties.sv ----
// timing checks on the host bus port outputs
`timescale 1ns/1ps
module lcd_host_bus_port_properties (
    input wire logic                     clk_sys,
    input wire logic                     rstn,
    input wire logic                     link_clk,
    input wire logic [3:0]               avs_address,
    input wire logic                     avs_read,
    input wire logic                     avs_write,
    input wire logic [31:0]              avs_writedata,
    input wire logic [31:0]              avs_readdata,
    input wire logic                     avs_waitrequest,
    input wire lcd_port_pkg::host_pins_t pins,
    input wire logic                     init_pin_n,
    input wire logic [7:0]               data_out,
    input wire logic [7:0]               data_oe
);
    import lcd_port_pkg::*;
    // ****************************************
    // register bus
    // ****************************************
    chk_wait_one: assert property (@(posedge clk_sys) disable iff (!rstn)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("no ack");
    chk_wait_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
        !avs_waitrequest |=> avs_waitrequest) else $error("ack too long");
    chk_ack_cause: assert property (@(posedge clk_sys) disable iff (!rstn)
        $fell(avs_waitrequest) |-> $past(avs_read || avs_write)) else $error("stray ack");
    chk_rdata_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata))
        else $error("readdata moved");
    // ****************************************
    // host data bus drivers, sampled coarsely at the link clock
    // ****************************************
    chk_oe_whole: assert property (@(posedge link_clk) disable iff (!rstn)
        data_oe == 8'h00 || data_oe == 8'hff) else $error("partial drive");
    chk_desel_float: assert property (@(posedge link_clk) disable iff (!rstn)
        pins.unit_select_n [*5] |-> data_oe == 8'h00) else $error("drives unselected");
    chk_serial_float: assert property (@(posedge link_clk) disable iff (!rstn)
        !pins.parallel [*5] |-> data_oe == 8'h00) else $error("drives in serial");
    chk_rd_drive: assert property (@(posedge link_clk) disable iff (!rstn)
        (pins.parallel && !pins.style && !pins.unit_select_n && !pins.rd_e) [*5]
        |-> data_oe == 8'hff) else $error("no read drive");
    chk_rd_float: assert property (@(posedge link_clk) disable iff (!rstn)
        (pins.parallel && !pins.style && pins.rd_e) [*5] |-> data_oe == 8'h00)
        else $error("drives without read");
    chk_e_drive: assert property (@(posedge link_clk) disable iff (!rstn)
        (pins.parallel && pins.style && !pins.unit_select_n && pins.rd_e && pins.wr_rw) [*5]
        |-> data_oe == 8'hff) else $error("no enable read drive");
    chk_e_write: assert property (@(posedge link_clk) disable iff (!rstn)
        (pins.parallel && pins.style && !pins.wr_rw) [*5] |-> data_oe == 8'h00)
        else $error("drives on write");
endmodule

// ---- host_mpu_model.sv ----
// host processor model driving the display port pins
`timescale 1ns/1ps
module host_mpu_model (
    input  wire logic [7:0]          data_out,
    input  wire logic [7:0]          data_oe,
    input  wire logic                link_clk,
    output lcd_port_pkg::host_pins_t pins
);
    import lcd_port_pkg::*;
    logic       par, sty, dcr, usn, rde, rw, drv;
    logic [7:0] dv;
    // idle host: parallel 8080, deselected, strobes high
    initial begin
        {par, sty, dcr, usn, rde, rw, drv} = 7'b1001110;
        dv = 8'h3f;
    end
    // released bus shows the inverse of the last byte, never a stale copy
    always_comb begin
        pins = '{par, sty, dcr, usn, rde, rw, drv ? dv : (data_oe == 8'hff ? data_out : ~dv)};
    end
    task automatic hold(input int n);
        repeat (n) @(posedge link_clk);
    endtask
    task automatic set_mode(input logic p, input logic s);
        hold(1);
        par <= p;
        sty <= s;
        rde <= !s;
        rw <= 1'b1;
        drv <= !p;
        dv <= 8'h3f;
        hold(3);
    endtask
    task automatic wr(input logic sel, input logic dc, input logic [7:0] b);
        hold(1);
        usn <= !sel;
        dcr <= dc;
        dv <= b;
        drv <= 1'b1;
        rw <= 1'b0;
        if (sty) rde <= 1'b1;
        hold(3);
        if (sty) rde <= 1'b0;
        else rw <= 1'b1;
        hold(3);
        usn <= 1'b1;
        drv <= 1'b0;
        rw <= 1'b1;
    endtask
    task automatic rd(input logic dc, output logic [7:0] b, output logic [7:0] oe);
        hold(1);
        usn <= 1'b0;
        dcr <= dc;
        rde <= sty;
        hold(5);
        b = data_out;
        oe = data_oe;
        rde <= !sty;
        hold(4);
        usn <= 1'b1;
        hold(4);
    endtask
    // serial clock stands low between frames
    task automatic ser(input logic dc, input logic [7:0] b, input int n);
        hold(1);
        usn <= 1'b0;
        dcr <= dc;
        for (int i = 7; i > 7 - n; i--) begin
            dv <= {b[i], 7'h3f};
            hold(2);
            dv[6] <= 1'b1;
            hold(2);
        end
        dv <= 8'h3f;
        hold(2);
        usn <= 1'b1;
        hold(3);
    endtask
endmodule

// ---- tb_lcd_host_bus_port.sv ----
// testbench for the display host bus port
`timescale 1ns/1ps
module tb_lcd_host_bus_port;
    import lcd_port_pkg::*;
    localparam logic [31:0] O_ = 32'h1 << ST_OVERRUN_BIT, R_ = 32'h1 << ST_READ_BIT;
    localparam logic [31:0] P_ = 32'h1 << ST_PARALLEL_BIT, S_ = 32'h1 << ST_STYLE_BIT;
    localparam logic [31:0] I_ = 32'h1 << ST_INIT_BIT, V_ = 32'h1 << RX_VALID_BIT;
    logic        clk_sys, link_clk, rstn, init_pin_n;
    logic [3:0]  avs_address;
    logic        avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, d;
    logic [7:0]  data_out, data_oe, b, oe;
    host_pins_t  pins;
    int          bad_count = 0, compares = 0;
    always #2.5 clk_sys = ~clk_sys;
    // first link edge at 1.3 ns lands inside reset, so link flops start known
    initial begin
        link_clk = 1'b0;
        #1.3;
        forever begin
            link_clk = ~link_clk;
            #80;
        end
    end
    lcd_host_bus_port dut (.clk_sys(clk_sys), .rstn(rstn), .link_clk(link_clk),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pins(pins), .init_pin_n(init_pin_n),
        .data_out(data_out), .data_oe(data_oe));
    host_mpu_model m (.data_out(data_out), .data_oe(data_oe), .link_clk(link_clk), .pins(pins));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !w;
        avs_write <= w;
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rr(input logic [3:0] a, input logic [31:0] exp);
        av(1'b0, a, 32'h0, d);
        check(d, exp);
    endtask
    task automatic wrr(input logic [3:0] a, input logic [31:0] wd);
        av(1'b1, a, wd, d);
    endtask
    function automatic logic [31:0] rx(input logic dc, input logic [7:0] v);
        return V_ | (32'(dc) << RX_DC_BIT) | 32'(v);
    endfunction
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // hang guard, far beyond the roughly 38 us the sequence needs
    initial begin
        #400000;
        bad_count++;
        give_verdict;
    end
    initial begin
        clk_sys = 1'b0;
        rstn = 1'b0;
        init_pin_n = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        m.hold(4);
        rr(ADDR_STATUS, P_);
        rr(ADDR_RDDATA, 32'h0);
        wrr(ADDR_RDDATA, 32'h0000a55a);
        rr(ADDR_RDDATA, 32'h0000a55a);
        wrr(4'hc, 32'hffffffff);
        rr(4'hc, 32'h0);
        m.wr(1'b1, 1'b0, 8'h3c);
        m.hold(4);
        rr(ADDR_RX, rx(1'b0, 8'h3c));
        av(1'b0, ADDR_RX, 32'h0, d);
        check(d & V_, 32'h0);
        m.rd(1'b1, b, oe);
        check({16'h0, b, oe}, 32'h00005aff);
        m.rd(1'b0, b, oe);
        check({16'h0, b, oe}, 32'h0000a5ff);
        rr(ADDR_STATUS, P_ | R_);
        wrr(ADDR_STATUS, O_ | R_);
        rr(ADDR_STATUS, P_);
        m.wr(1'b1, 1'b1, 8'h11);
        m.wr(1'b1, 1'b1, 8'h22);
        m.hold(4);
        rr(ADDR_STATUS, P_ | O_);
        rr(ADDR_RX, rx(1'b1, 8'h22));
        wrr(ADDR_STATUS, O_);
        m.wr(1'b0, 1'b1, 8'h99);
        m.hold(4);
        av(1'b0, ADDR_RX, 32'h0, d);
        check(d & V_, 32'h0);
        m.set_mode(1'b1, 1'b1);
        rr(ADDR_STATUS, P_ | S_);
        m.wr(1'b1, 1'b1, 8'h81);
        m.hold(4);
        rr(ADDR_RX, rx(1'b1, 8'h81));
        m.rd(1'b0, b, oe);
        check({16'h0, b, oe}, 32'h0000a5ff);
        wrr(ADDR_STATUS, R_);
        m.set_mode(1'b0, 1'b0);
        rr(ADDR_STATUS, 32'h0);
        // a cut frame must not leave stray bits behind
        m.ser(1'b1, 8'hc6, 3);
        m.ser(1'b1, 8'hc6, 8);
        m.hold(4);
        rr(ADDR_RX, rx(1'b1, 8'hc6));
        m.ser(1'b0, 8'h5e, 8);
        m.hold(4);
        rr(ADDR_RX, rx(1'b0, 8'h5e));
        m.set_mode(1'b1, 1'b0);
        m.wr(1'b1, 1'b1, 8'h77);
        m.hold(4);
        init_pin_n <= 1'b0;
        m.hold(8);
        rr(ADDR_STATUS, P_ | I_);
        init_pin_n <= 1'b1;
        m.hold(4);
        rr(ADDR_RX, 32'h0);
        rr(ADDR_RDDATA, 32'h0);
        give_verdict;
    end
endmodule
bind lcd_host_bus_port lcd_host_bus_port_properties chk (.clk_sys(clk_sys), .rstn(rstn),
    .link_clk(link_clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pins(pins), .init_pin_n(init_pin_n),
    .data_out(data_out), .data_oe(data_oe));
